// [common/ddr2_pin_pkg.sv]
// Shared constants and types for the DDR2 pin front end
package ddr2_pin_pkg;

   // ------------------------------------------------------------
   // Widths and field positions
   // ------------------------------------------------------------
   localparam int ADDR_W       = 14;
   localparam int COL_W        = 10;
   localparam int AP_BIT       = 10;
   localparam int BANK_W       = 3;
   localparam int DATA_W       = 16;
   localparam int BYTE_W       = 8;
   localparam int LANES        = 2;
   localparam int WORD_W       = DATA_W + LANES;
   localparam int FIFO_DEPTH   = 16;
   localparam int CTRL_PINS    = 7;
   localparam int PIN_W        = CTRL_PINS + BANK_W + ADDR_W + 1
                                 + DATA_W + 2 * LANES;
   localparam int EMR_DIFF_BIT = 10;

   // ------------------------------------------------------------
   // Mode register selection and burst size
   // ------------------------------------------------------------
   localparam logic [BANK_W-1:0] BANK_EMR_ONE = 3'h1;
   localparam logic [2:0]        BURST_BEATS  = 3'h4;

   // ------------------------------------------------------------
   // Command codes on row strobe, column strobe, write enable
   // ------------------------------------------------------------
   localparam logic [2:0] CODE_MODE_SET  = 3'h0;
   localparam logic [2:0] CODE_REFRESH   = 3'h1;
   localparam logic [2:0] CODE_PRECHARGE = 3'h2;
   localparam logic [2:0] CODE_ACTIVATE  = 3'h3;
   localparam logic [2:0] CODE_WRITE     = 3'h4;
   localparam logic [2:0] CODE_READ      = 3'h5;
   localparam logic [2:0] CODE_STOP      = 3'h6;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_MODE_SET,
      CMD_REFRESH,
      CMD_PRECHARGE,
      CMD_ACTIVATE,
      CMD_WRITE,
      CMD_READ,
      CMD_STOP
   } cmd_t;

endpackage

// [common/beat_if.sv]
// Valid/ready word channel between front end and write buffer
`timescale 1ns/10ps
`default_nettype none

interface beat_if #(parameter int W = 18);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// [logic/beat_fifo.sv]
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module beat_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   beat_if.snk      fill,
   beat_if.src      drain
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;
   logic [AW:0]  count;
   logic         do_push;
   logic         do_pop;

   assign count       = wr_ptr - rd_ptr;
   assign fill.ready  = count != FULL_COUNT;
   assign drain.valid = count != '0;
   assign drain.data  = mem[rd_ptr[AW-1:0]];
   assign do_push     = fill.valid & fill.ready;
   assign do_pop      = drain.valid & drain.ready;

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wr_ptr[AW-1:0]] <= fill.data;
      end
   end

   // ------------------------------------------------------------
   // Pointers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// [logic/ddr2_pin_front.sv]
// DDR2 device pin front end: command decode, strobes, write buffer
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Contract
// RL1 - Activate latches all fourteen row address lines
// RL2 - Column on ten low lines, bit ten autoprecharge
// RL3 - Bank select latched with each command
// RL4 - Lower strobe times low byte, upper high
// RL5 - Read strobe edge-aligned; write strobe centred
// RL6 - Complement strobe only in differential mode
// RL7 - Termination follows registered termination control
// RL8 - Deselected chip ignores every command
// RL9 - Command decoded from strobes on one edge
// RL10 - Masked write beats are never stored; code drops only fully masked beats, stores partly masked ones
// RL11 - Write mask sampled on both strobe edges
// RL12 - Control inputs sampled on rising clock crossing
// RL13 - Read data beat on each clock crossing
// RL14 - Clock enable gates internal clocking
// ---------------------------------------------------------------

module ddr2_pin_front
   import ddr2_pin_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                mem_clk,
   input  wire logic                mem_clk_n,
   input  wire logic                clock_enable,
   input  wire logic                chip_select_n,
   input  wire logic                row_strobe_n,
   input  wire logic                col_strobe_n,
   input  wire logic                write_enable_n,
   input  wire logic [BANK_W-1:0]   bank_select,
   input  wire logic [ADDR_W-1:0]   address_lines,
   input  wire logic                termination_control,
   input  wire logic [DATA_W-1:0]   data_lines_in,
   output logic      [DATA_W-1:0]   data_lines_out,
   output logic                     data_lines_oe_n,
   input  wire logic                lower_byte_strobe_in,
   output logic                     lower_byte_strobe_out,
   output logic                     lower_byte_strobe_oe_n,
   input  wire logic                lower_byte_strobe_n_in,
   output logic                     lower_byte_strobe_n_out,
   output logic                     lower_byte_strobe_n_oe_n,
   input  wire logic                upper_byte_strobe_in,
   output logic                     upper_byte_strobe_out,
   output logic                     upper_byte_strobe_oe_n,
   input  wire logic                upper_byte_strobe_n_in,
   output logic                     upper_byte_strobe_n_out,
   output logic                     upper_byte_strobe_n_oe_n,
   input  wire logic                lower_write_mask,
   input  wire logic                upper_write_mask,
   output logic                     termination_on,
   output logic                     clocking_active,
   output logic                     diff_strobe,
   output logic                     cmd_valid,
   output var cmd_t                 cmd_code,
   output logic      [BANK_W-1:0]   cmd_bank,
   output logic      [ADDR_W-1:0]   cmd_row,
   output logic      [COL_W-1:0]    cmd_col,
   output logic                     cmd_auto_precharge,
   input  wire logic                rd_valid,
   input  wire logic [DATA_W-1:0]   rd_data,
   output logic                     rd_ready,
   output logic                     wr_valid,
   input  wire logic                wr_ready,
   output logic      [DATA_W-1:0]   wr_data,
   output logic      [LANES-1:0]    wr_keep,
   output logic                     write_overflow,
   input  wire logic                write_overflow_clear
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [PIN_W-1:0]  pin_meta;
   logic [PIN_W-1:0]  pin_s2;
   logic              clk_s;
   logic              clk_n_s;
   logic              cke_s;
   logic              cs_n_s;
   logic              ras_n_s;
   logic              cas_n_s;
   logic              we_n_s;
   logic [BANK_W-1:0] bank_s;
   logic [ADDR_W-1:0] addr_s;
   logic              term_s;
   logic [DATA_W-1:0] data_s;
   logic [LANES-1:0]  strobe_s;
   logic [LANES-1:0]  mask_s;
   logic              clk_prev;
   logic [LANES-1:0]  strobe_prev;
   logic              clk_rise;
   logic              clk_edge;
   logic [LANES-1:0]  strobe_edge;
   logic              cmd_take;
   cmd_t              next_code;
   logic [2:0]        wr_left;
   logic [LANES-1:0]  lane_got;
   logic [DATA_W-1:0] lane_data;
   logic [LANES-1:0]  lane_mask;
   logic [LANES-1:0]  next_got;
   logic [DATA_W-1:0] next_data;
   logic [LANES-1:0]  next_mask;
   logic              beat_done;
   logic [2:0]        rd_left;
   logic              read_strobe;

   beat_if #(.W(WORD_W)) push_if ();
   beat_if #(.W(WORD_W)) pop_if ();

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= '0;
         pin_s2   <= '0;
      end else begin
         pin_meta <= {mem_clk, mem_clk_n, clock_enable, chip_select_n,
                      row_strobe_n, col_strobe_n, write_enable_n,
                      bank_select, address_lines, termination_control,
                      data_lines_in, upper_byte_strobe_in,
                      lower_byte_strobe_in, upper_write_mask,
                      lower_write_mask};
         pin_s2   <= pin_meta;
      end
   end

   assign {clk_s, clk_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
           bank_s, addr_s, term_s, data_s, strobe_s, mask_s} = pin_s2;

   // ------------------------------------------------------------
   // Edge detection on link clock and strobes
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clk_prev    <= 1'b0;
         strobe_prev <= '0;
      end else begin
         clk_prev    <= clk_s;
         strobe_prev <= strobe_s;
      end
   end

   // True clock rising while complement is low
   assign clk_rise    = clk_s & ~clk_prev & ~clk_n_s; // RL12
   assign clk_edge    = clk_s ^ clk_prev; // RL13
   assign strobe_edge = (strobe_s ^ strobe_prev)
                        & {LANES{data_lines_oe_n}}; // RL11

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   always_comb begin
      case ({ras_n_s, cas_n_s, we_n_s}) // RL9
         CODE_MODE_SET:  next_code = CMD_MODE_SET;
         CODE_REFRESH:   next_code = CMD_REFRESH;
         CODE_PRECHARGE: next_code = CMD_PRECHARGE;
         CODE_ACTIVATE:  next_code = CMD_ACTIVATE;
         CODE_WRITE:     next_code = CMD_WRITE;
         CODE_READ:      next_code = CMD_READ;
         CODE_STOP:      next_code = CMD_STOP;
         default:        next_code = CMD_NOP;
      endcase
   end

   // Deselect or stopped clocking masks the command
   assign cmd_take = clk_rise & cke_s & clocking_active & ~cs_n_s; // RL8

   // ------------------------------------------------------------
   // Clock enable and termination
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clocking_active <= 1'b0;
         termination_on  <= 1'b0;
      end else if (clk_rise) begin
         clocking_active <= cke_s; // RL14
         termination_on  <= term_s; // RL7
      end
   end

   // ------------------------------------------------------------
   // Command register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_valid          <= 1'b0;
         cmd_code           <= CMD_NOP;
         cmd_bank           <= '0;
         cmd_row            <= '0;
         cmd_col            <= '0;
         cmd_auto_precharge <= 1'b0;
      end else begin
         cmd_valid <= cmd_take && next_code != CMD_NOP;
         if (cmd_take) begin
            cmd_code <= next_code; // RL9
            cmd_bank <= bank_s; // RL3
            if (next_code == CMD_ACTIVATE) begin
               cmd_row <= addr_s; // RL1
            end
            if (next_code == CMD_READ || next_code == CMD_WRITE) begin
               cmd_col            <= addr_s[COL_W-1:0]; // RL2
               cmd_auto_precharge <= addr_s[AP_BIT]; // RL2
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Strobe mode from first extended mode register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         diff_strobe <= 1'b0;
      end else if (cmd_take && next_code == CMD_MODE_SET
                   && bank_s == BANK_EMR_ONE) begin
         // Bit set disables the complementary strobe
         diff_strobe <= ~addr_s[EMR_DIFF_BIT]; // RL6
      end
   end

   // ------------------------------------------------------------
   // Write capture, one byte lane per strobe
   // ------------------------------------------------------------
   always_comb begin
      next_got  = lane_got;
      next_data = lane_data;
      next_mask = lane_mask;
      for (int i = 0; i < LANES; i++) begin
         if (strobe_edge[i]) begin
            next_got[i]                   = 1'b1;
            next_data[i*BYTE_W +: BYTE_W] = data_s[i*BYTE_W +: BYTE_W];
            next_mask[i]                  = mask_s[i]; // RL11
         end
      end
   end

   assign beat_done = !(cmd_take && next_code == CMD_WRITE)
                      && wr_left != '0 && &next_got;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_left      <= '0;
         lane_got     <= '0;
         lane_data    <= '0;
         lane_mask    <= '0;
         push_if.valid <= 1'b0;
         push_if.data  <= '0;
      end else begin
         push_if.valid <= 1'b0;
         if (cmd_take && next_code == CMD_WRITE) begin
            wr_left  <= BURST_BEATS;
            lane_got <= '0;
         end else if (wr_left != '0) begin
            lane_data <= next_data; // RL4
            lane_mask <= next_mask;
            if (beat_done) begin
               lane_got <= '0;
               wr_left  <= wr_left - 3'h1;
               // Fully masked beat never reaches the buffer
               if (!(&next_mask)) begin // RL10
                  push_if.valid <= push_if.ready;
                  push_if.data  <= {~next_mask, next_data};
               end
            end else begin
               lane_got <= next_got;
            end
         end
      end
   end

   // Lost beat when the buffer was full; set beats clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         write_overflow <= 1'b0;
      end else if (beat_done && !(&next_mask) && !push_if.ready) begin
         write_overflow <= 1'b1;
      end else if (write_overflow_clear) begin
         write_overflow <= 1'b0;
      end
   end

   beat_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_write_buf (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .fill    (push_if.snk),
      .drain   (pop_if.src)
   );

   assign pop_if.ready = wr_ready;
   assign wr_valid     = pop_if.valid;
   assign wr_data      = pop_if.data[DATA_W-1:0];
   assign wr_keep      = pop_if.data[WORD_W-1:DATA_W];

   // ------------------------------------------------------------
   // Read drive, one beat per clock crossing
   // ------------------------------------------------------------
   assign rd_ready = clk_edge && rd_left != '0
                     && !(cmd_take && next_code == CMD_READ);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_left         <= '0;
         data_lines_out  <= '0;
         data_lines_oe_n <= 1'b1;
         read_strobe     <= 1'b0;
      end else if (cmd_take && next_code == CMD_READ) begin
         rd_left <= BURST_BEATS;
      end else if (clk_edge) begin
         if (rd_left != '0 && rd_valid) begin
            data_lines_out  <= rd_data; // RL13
            data_lines_oe_n <= 1'b0;
            read_strobe     <= ~read_strobe; // RL5
            rd_left         <= rd_left - 3'h1;
         end else if (rd_left == '0) begin
            data_lines_oe_n <= 1'b1;
            read_strobe     <= 1'b0;
         end
      end
   end

   // Both lanes share one edge-aligned strobe on reads
   assign lower_byte_strobe_out    = read_strobe; // RL4
   assign lower_byte_strobe_oe_n   = data_lines_oe_n;
   assign upper_byte_strobe_out    = read_strobe;
   assign upper_byte_strobe_oe_n   = data_lines_oe_n;
   assign lower_byte_strobe_n_out  = ~read_strobe;
   assign lower_byte_strobe_n_oe_n = data_lines_oe_n | ~diff_strobe; // RL6
   assign upper_byte_strobe_n_out  = ~read_strobe;
   assign upper_byte_strobe_n_oe_n = data_lines_oe_n | ~diff_strobe; // RL6

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_write_cmd;
      cmd_take && next_code == CMD_WRITE;
   endsequence

   sequence s_rw_cmd;
      cmd_take && (next_code == CMD_READ || next_code == CMD_WRITE);
   endsequence

   sequence s_masked_beat;
      beat_done && &next_mask;
   endsequence

   sequence s_read_beat;
      rd_ready && rd_valid;
   endsequence

   a_cs_masks_cmd: assert property ( // RL8
      clk_rise && cs_n_s |=> !cmd_valid)
      else $error("command taken while deselected");

   a_rise_only: assert property ( // RL12
      !clk_rise |=> !cmd_valid)
      else $error("command taken off the rising crossing");

   a_term_follow: assert property ( // RL7
      clk_rise |=> termination_on == $past(term_s))
      else $error("termination not following control");

   a_cke_follow: assert property ( // RL14
      clk_rise ##1 !clocking_active |-> !cmd_take [*2])
      else $error("command taken with clocking off");

   a_row_latch: assert property ( // RL1
      cmd_take && next_code == CMD_ACTIVATE |=>
         cmd_valid && cmd_code == CMD_ACTIVATE && cmd_row == $past(addr_s))
      else $error("activate row not latched");

   a_col_latch: assert property ( // RL2
      s_rw_cmd |=> cmd_col == $past(addr_s[COL_W-1:0])
         && cmd_auto_precharge == $past(addr_s[AP_BIT]))
      else $error("column or autoprecharge not latched");

   a_bank_latch: assert property ( // RL3
      cmd_take |=> cmd_bank == $past(bank_s))
      else $error("bank select not latched");

   a_decode_write: assert property ( // RL9
      s_write_cmd |=> cmd_valid && cmd_code == CMD_WRITE
         && wr_left == BURST_BEATS)
      else $error("write command not decoded");

   a_mask_drop: assert property ( // RL10
      s_masked_beat |=> !push_if.valid)
      else $error("masked beat stored");

   a_mask_sample: assert property ( // RL11
      strobe_edge[0] && wr_left != '0 && !cmd_take |=>
         lane_mask[0] == $past(mask_s[0])
         && lane_data[BYTE_W-1:0] == $past(data_s[BYTE_W-1:0]))
      else $error("lower lane not sampled on strobe edge");

   a_strobe_diff: assert property ( // RL6
      !diff_strobe |-> lower_byte_strobe_n_oe_n
         && upper_byte_strobe_n_oe_n)
      else $error("complement strobe driven in single mode");

   a_read_beat: assert property ( // RL13
      s_read_beat |=> !data_lines_oe_n
         && data_lines_out == $past(rd_data)
         && read_strobe != $past(read_strobe))
      else $error("read beat not driven with strobe edge");

   a_strobe_quiet: assert property ( // RL5
      !clk_edge |=> $stable(read_strobe))
      else $error("read strobe moved off a clock crossing");

endmodule

`default_nettype wire

// [testbench/ddr2_ctrl_model.sv]
// Behavioural memory controller driving the link pins
`timescale 1ns/10ps
`default_nettype none

module ddr2_ctrl_model
   import ddr2_pin_pkg::*;
(
   output logic              mem_clk,
   output logic              mem_clk_n,
   output logic              clock_enable,
   output logic              chip_select_n,
   output logic [2:0]        cmd_pins,
   output logic [BANK_W-1:0] bank_select,
   output logic [ADDR_W-1:0] address_lines,
   output logic              termination_control,
   output logic [DATA_W-1:0] dq,
   output logic              strobe,
   output logic [LANES-1:0]  mask
);
   assign mem_clk_n = ~mem_clk;

   initial begin
      mem_clk = 1'b0;
      clock_enable = 1'b1;
      chip_select_n = 1'b1;
      cmd_pins = 3'h7;
      bank_select = 3'h0;
      address_lines = 14'h0000;
      termination_control = 1'b0;
      dq = 16'h0000;
      strobe = 1'b0;
      mask = 2'h0;
      #3;
      forever #40 mem_clk = ~mem_clk;
   end

   // Set up half a period early, held across the rise, then released
   task automatic command(input logic cs_n, input logic [2:0] code,
                          input logic [BANK_W-1:0] bank,
                          input logic [ADDR_W-1:0] addr);
      @(negedge mem_clk);
      chip_select_n = cs_n;
      cmd_pins = code;
      bank_select = bank;
      address_lines = addr;
      @(posedge mem_clk);
      @(negedge mem_clk);
      chip_select_n = 1'b1;
      cmd_pins = 3'h7;
      address_lines = ~addr;
   endtask

   // Strobe edge in the middle of the data window
   task automatic beat(input logic [DATA_W-1:0] d, input logic [1:0] m);
      dq = d;
      mask = m;
      #20 strobe = ~strobe;
      #20 dq = ~d;
      mask = ~m;
   endtask
endmodule

`default_nettype wire

// [testbench/ddr2_pin_front_tb_top.sv]
// Self-checking bench for the DDR2 pin front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end

module ddr2_pin_front_tb_top;
   import ddr2_pin_pkg::*;
   logic ref_clk, nrst, mem_clk, mem_clk_n, clock_enable, chip_select_n;
   logic termination_control, strobe, lstb, ustb, prev_stb;
   logic [2:0] cmd_pins;
   logic [BANK_W-1:0] bank_select, cmd_bank;
   logic [ADDR_W-1:0] address_lines, cmd_row;
   logic [DATA_W-1:0] dq, data_lines_in, data_lines_out, rd_data, wr_data;
   logic [LANES-1:0] mask, wr_keep;
   logic [COL_W-1:0] cmd_col;
   logic data_lines_oe_n, lower_byte_strobe_out, upper_byte_strobe_out;
   logic lower_byte_strobe_oe_n, upper_byte_strobe_oe_n;
   logic lower_byte_strobe_n_oe_n, termination_on, clocking_active;
   logic diff_strobe, cmd_valid, cmd_auto_precharge, rd_valid, rd_ready;
   logic wr_valid, wr_ready, write_overflow, write_overflow_clear;
   cmd_t cmd_code;
   int failures, tests_run, cycles, n_cmd;
   logic [DATA_W-1:0] rd_seen[$];
   logic [WORD_W-1:0] wr_q[$];

   // Wire level from the front end's output enables
   assign data_lines_in = data_lines_oe_n ? dq : data_lines_out;
   assign lstb = lower_byte_strobe_oe_n ? strobe : lower_byte_strobe_out;
   assign ustb = upper_byte_strobe_oe_n ? strobe : upper_byte_strobe_out;

   ddr2_ctrl_model ddr2_ctrl_model_i (.mem_clk, .mem_clk_n, .clock_enable,
      .chip_select_n, .cmd_pins, .bank_select, .address_lines,
      .termination_control, .dq, .strobe, .mask);

   ddr2_pin_front ddr2_pin_front_i (.ref_clk, .nrst, .mem_clk, .mem_clk_n,
      .clock_enable, .chip_select_n, .row_strobe_n(cmd_pins[2]),
      .col_strobe_n(cmd_pins[1]), .write_enable_n(cmd_pins[0]),
      .bank_select, .address_lines, .termination_control, .data_lines_in,
      .data_lines_out, .data_lines_oe_n, .lower_byte_strobe_in(lstb),
      .lower_byte_strobe_out, .lower_byte_strobe_oe_n,
      .lower_byte_strobe_n_in(~lstb), .lower_byte_strobe_n_out(),
      .lower_byte_strobe_n_oe_n, .upper_byte_strobe_in(ustb),
      .upper_byte_strobe_out, .upper_byte_strobe_oe_n,
      .upper_byte_strobe_n_in(~ustb), .upper_byte_strobe_n_out(),
      .upper_byte_strobe_n_oe_n(), .lower_write_mask(mask[0]),
      .upper_write_mask(mask[1]), .termination_on, .clocking_active,
      .diff_strobe, .cmd_valid, .cmd_code, .cmd_bank, .cmd_row, .cmd_col,
      .cmd_auto_precharge, .rd_valid, .rd_data, .rd_ready, .wr_valid,
      .wr_ready, .wr_data, .wr_keep, .write_overflow, .write_overflow_clear);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Monitors
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      prev_stb <= lower_byte_strobe_out;
      if (cmd_valid === 1'b1) n_cmd++;
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         wr_q.push_back({wr_keep, wr_data});
      if (rd_valid === 1'b1 && rd_ready === 1'b1) rd_data <= rd_data + 16'h1;
      if (data_lines_oe_n === 1'b0 && lower_byte_strobe_out !== prev_stb) begin
         rd_seen.push_back(data_lines_out);
         `CHK(upper_byte_strobe_out, lower_byte_strobe_out)
         `CHK(lower_byte_strobe_n_oe_n, 1'b0)
      end
      if (cycles > 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic cmd_chk(input logic cs_n, input logic [2:0] code,
                          input logic [BANK_W-1:0] b,
                          input logic [ADDR_W-1:0] a, input int exp_n);
      int n0;
      n0 = n_cmd;
      ddr2_ctrl_model_i.command(cs_n, code, b, a);
      repeat (8) @(posedge ref_clk);
      `CHK(n_cmd - n0, exp_n)
   endtask

   task automatic test_codes();
      for (int c = 0; c < 8; c++) begin
         cmd_chk(1'b0, c[2:0], 3'h0, 14'h0000, int'(c < 7));
         if (c < 7) `CHK(cmd_code, cmd_t'(c + 1))
         cmd_chk(1'b1, c[2:0], 3'h0, 14'h0000, 0);
      end
   endtask

   task automatic test_fields();
      cmd_chk(1'b0, CODE_ACTIVATE, 3'h7, 14'h3FFF, 1);
      `CHK(cmd_row, 14'h3FFF)
      `CHK(cmd_bank, 3'h7)
      cmd_chk(1'b0, CODE_READ, 3'h2, 14'h15A5, 1);
      `CHK(cmd_col, 10'h1A5)
      `CHK(cmd_auto_precharge, 1'b1)
      `CHK(cmd_bank, 3'h2)
   endtask

   task automatic test_pins();
      #1 ddr2_ctrl_model_i.termination_control = 1'b1;
      repeat (20) @(posedge ref_clk);
      `CHK(termination_on, 1'b1)
      #1 ddr2_ctrl_model_i.termination_control = 1'b0;
      repeat (20) @(posedge ref_clk);
      `CHK(termination_on, 1'b0)
      cmd_chk(1'b0, CODE_MODE_SET, BANK_EMR_ONE, 14'h0400, 1);
      `CHK(diff_strobe, 1'b0)
      cmd_chk(1'b0, CODE_MODE_SET, BANK_EMR_ONE, 14'h0000, 1);
      `CHK(diff_strobe, 1'b1)
      #1 ddr2_ctrl_model_i.clock_enable = 1'b0;
      repeat (20) @(posedge ref_clk);
      `CHK(clocking_active, 1'b0)
      cmd_chk(1'b0, CODE_ACTIVATE, 3'h0, 14'h0000, 0);
      #1 ddr2_ctrl_model_i.clock_enable = 1'b1;
      repeat (20) @(posedge ref_clk);
      `CHK(clocking_active, 1'b1)
   endtask

   task automatic test_read();
      logic [DATA_W-1:0] base;
      rd_seen.delete();
      base = rd_data;
      cmd_chk(1'b0, CODE_READ, 3'h0, 14'h0000, 1);
      #1 rd_valid = 1'b1;
      repeat (60) @(posedge ref_clk);
      #1 rd_valid = 1'b0;
      `CHK(rd_seen.size(), 4)
      `CHK(rd_seen[0], base)
      `CHK(rd_seen[3], base + 16'h3)
      `CHK(data_lines_oe_n, 1'b1)
   endtask

   task automatic test_write();
      wr_q.delete();
      for (int b = 0; b < 5; b++) begin
         cmd_chk(1'b0, CODE_WRITE, 3'h1, 14'h0A5A, 1);
         `CHK(cmd_auto_precharge, 1'b0)
         for (int i = 0; i < 4; i++)
            ddr2_ctrl_model_i.beat({8'(b), 8'(i)},
               (b == 0 && i == 1) ? 2'h3 : (b == 0 && i == 2) ? 2'h1 : 2'h0);
      end
      repeat (10) @(posedge ref_clk);
      `CHK(write_overflow, 1'b1)
      @(posedge ref_clk) #1 wr_ready = 1'b1;
      repeat (40) @(posedge ref_clk);
      #1 wr_ready = 1'b0;
      `CHK(wr_q.size(), 16)
      `CHK(wr_q[0], {2'h3, 16'h0000})
      `CHK(wr_q[1][17:8], {2'h2, 8'h00})
      `CHK(wr_q[15], {2'h3, 16'h0400})
      `CHK(wr_valid, 1'b0)
      write_overflow_clear = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 write_overflow_clear = 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK(write_overflow, 1'b0)
   endtask

   initial begin
      nrst = 1'b0;
      rd_valid = 1'b0;
      rd_data = 16'h00A0;
      wr_ready = 1'b0;
      write_overflow_clear = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (30) @(posedge ref_clk);
      test_codes();
      test_fields();
      test_pins();
      test_read();
      test_write();
      end_sim();
   end
endmodule

`default_nettype wire
